// *** hw/gcd_control_decoder.sv ***
// control word subcommand decoder with rate, temperature and voltage words
// assumes a word-wide register port at even command codes, synchronous to sys_clk;
// the host holds a request until regReady is high
`timescale 1ns/1ps
`include "gcd_defs.svh"
module gcd_control_decoder
  import gcd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES    = `GCD_TICK_S * `GCD_CLK_HZ,
  parameter int unsigned STRETCH_CYCLES = (`GCD_STRETCH_MS * `GCD_CLK_HZ + 999) / 1000,
  // identification words: values are arbitrary
  parameter logic [15:0] DEVICE_TYPE    = 16'h0A5A,
  parameter logic [15:0] FW_REV         = 16'h0100,
  parameter logic [15:0] HW_REV         = 16'h00A0,
  parameter logic [15:0] PROFILE_ID     = 16'h0001,
  parameter logic [15:0] FLASH_REV      = 16'h0001
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // register port
  input  wire logic [7:0]         regAddr,
  input  wire logic               regWrEn,
  input  wire logic               regRdEn,
  input  wire gcd_pkg::gcd_word_t regWrData,
  output logic                    regReady,
  output gcd_pkg::gcd_word_t      regRdData,
  output logic                    regRdValid,
  // link
  input  wire logic               wireMode,
  output logic                    clockStretch,
  output logic                    msgDropped,
  // power modes
  input  wire logic               sleepEntered,
  input  wire logic               hibernateWake,
  output logic                    fullSleepMode,
  output logic                    hibernateMode,
  // power-off pin
  input  wire logic               shutdownCond,
  output logic                    sePinOut,
  output logic                    sePinOen,
  // single-wire interrupt
  input  wire logic               irqCondition,
  input  wire logic [7:0]         irqRetryCount,
  output logic                    wireIrqPulse,
  // algorithm side
  input  wire logic               voltageUnsuitable,
  input  wire logic               coulombCalActive,
  input  wire logic               boardCalActive,
  input  wire logic               constantPowerMode,
  input  wire logic               raUpdatesOff,
  input  wire gcd_pkg::gcd_word_t flashSum,
  input  wire gcd_pkg::gcd_word_t resetInfo,
  input  wire gcd_pkg::gcd_word_t predTimeIn,
  input  wire gcd_pkg::gcd_word_t tempIn,
  input  wire gcd_pkg::gcd_word_t voltIn,
  output logic                    trackingStart,
  output logic [7:0]              updateStatus,
  output logic                    sumStart,
  output logic                    calStart,
  output logic                    fullResetReq
);
  import gcd_pkg::*;

  // state
  logic      sealed_q;
  logic      sumValid_q;
  logic      wireIrqEnable_q;
  logic      shutdownEn_q;
  logic      hibernateReq_q;
  logic      deepDoze_q;
  logic      voltageOk_q;
  logic      capUpdateOn_q;
  logic      loadMode_q;
  logic      deep_doze_q;
  logic      hibernate_q;
  logic      pinLow_q;
  logic [7:0] irqTries_q;
  gcd_ret_t  retSel_q;
  gcd_ret_t  retSel_d;
  gcd_word_t retWord_q;
  gcd_word_t retWord_d;
  gcd_word_t sum_q;
  gcd_word_t lastCmd_q;
  gcd_word_t rate_q;
  logic      tick;
  logic      stretchBusy;
  gcd_word_t rateTime;
  gcd_word_t temperature;
  gcd_word_t packVoltage;

  // access arbitration
  wire logic req       = regWrEn | regRdEn;
  // two-wire traffic held in full sleep and while the oscillator restarts
  assign regReady      = ~stretchBusy & ~(deep_doze_q & ~wireMode);
  // single-wire message in full sleep is taken and thrown away
  wire logic dropNow   = deep_doze_q & wireMode & req;
  wire logic wakeNow   = deep_doze_q & req;
  wire logic commEvent = req & regReady;
  wire logic acc       = commEvent & ~dropNow;
  wire logic wrCtl     = acc & regWrEn & (regAddr == `GCD_OFF_CTL);
  wire logic wrRate    = acc & regWrEn & (regAddr == `GCD_OFF_RATE);
  wire logic rdAcc     = acc & regRdEn & ~regWrEn;

  wire gcd_word_t cmd  = regWrData;
  wire logic isSum     = cmd == `GCD_SC_SUM;
  wire logic isRstData = cmd == `GCD_SC_RSTDATA;
  wire logic isPrev    = cmd == `GCD_SC_PREV;
  wire logic isDoze    = cmd == `GCD_SC_DOZE;
  wire logic isSeal    = cmd == `GCD_SC_SEAL;
  wire logic isTrack   = cmd == `GCD_SC_TRACK;
  wire logic isCal     = cmd == `GCD_SC_CAL;
  wire logic isReset   = cmd == `GCD_SC_RESET;
  wire logic restricted = isSum | isRstData | (cmd == `GCD_SC_RSVD) | isPrev | isDoze |
                          isSeal | isTrack | isCal | isReset;
  // sealed checksum may still read back the stored sum
  wire logic sumRead   = wrCtl & isSum & sealed_q;
  wire logic doCmd     = wrCtl & ~(sealed_q & restricted);
  wire logic doHibSet  = doCmd & (cmd == `GCD_SC_HIB_SET);
  wire logic doHibClr  = doCmd & (cmd == `GCD_SC_HIB_CLR);
  wire logic doSdSet   = doCmd & (cmd == `GCD_SC_SD_SET);
  wire logic doSdClr   = doCmd & (cmd == `GCD_SC_SD_CLR);
  wire logic doIrqOn   = doCmd & (cmd == `GCD_SC_IRQ_ON);
  wire logic doIrqOff  = doCmd & (cmd == `GCD_SC_IRQ_OFF);
  wire logic doSum     = doCmd & isSum;
  wire logic doDoze    = doCmd & isDoze;
  wire logic doSeal    = doCmd & isSeal;
  wire logic doTrack   = doCmd & isTrack;

  wire logic sePinActive = shutdownEn_q & pinLow_q;
  wire gcd_word_t statusWord = {
    sePinActive, sealed_q, sealed_q, sumValid_q,
    coulombCalActive, boardCalActive, 1'b0, wireIrqEnable_q,
    shutdownEn_q, hibernateReq_q, deepDoze_q, sleepEntered,
    loadMode_q, raUpdatesOff, voltageOk_q, capUpdateOn_q};

  // returned control word selection
  always_comb begin
    retSel_d  = retSel_q;
    retWord_d = retWord_q;
    if (doCmd | sumRead) begin
      case (cmd)
        `GCD_SC_STATUS: begin
          retSel_d = GCD_RET_STATUS;
        end
        `GCD_SC_DEVTYPE: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = DEVICE_TYPE;
        end
        `GCD_SC_FWREV: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = FW_REV;
        end
        `GCD_SC_HWREV: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = HW_REV;
        end
        `GCD_SC_PROFILE: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = PROFILE_ID;
        end
        `GCD_SC_FLASHREV: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = FLASH_REV;
        end
        // fresh sum when open, stored sum when sealed
        `GCD_SC_SUM: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = sealed_q ? sum_q : flashSum;
        end
        `GCD_SC_RSTDATA: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = resetInfo;
        end
        `GCD_SC_PREV: begin
          retSel_d  = GCD_RET_WORD;
          retWord_d = lastCmd_q;
        end
        default: begin
          retSel_d  = retSel_q;
          retWord_d = retWord_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      retSel_q  <= GCD_RET_STATUS;
      retWord_q <= `GCD_RESET_WORD;
    end else begin
      retSel_q  <= retSel_d;
      retWord_q <= retWord_d;
    end
  end

  // only codes below the seal code are remembered
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      lastCmd_q <= 16'h0000;
    else if (wrCtl && cmd < `GCD_SC_SEAL)
      lastCmd_q <= cmd;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sum_q      <= 16'h0000;
      sumValid_q <= 1'b0;
    end else if (doSum) begin
      sum_q      <= flashSum;
      sumValid_q <= 1'b1;
    end
  end

  // seal transition; sealed state only leaves by reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      sealed_q <= 1'b0;
    else if (doSeal)
      sealed_q <= 1'b1;
  end

  // tracking start flags; voltage ok drops on unsuitable voltage, set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      voltageOk_q   <= 1'b0;
      capUpdateOn_q <= 1'b0;
      updateStatus  <= 8'h00;
    end else begin
      if (doTrack) begin
        voltageOk_q   <= 1'b1;
        capUpdateOn_q <= 1'b1;
        updateStatus  <= `GCD_UPD_STATUS;
      end else if (voltageUnsuitable) begin
        voltageOk_q <= 1'b0;
      end
    end
  end

  // load mode follows algorithm, zero from reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      loadMode_q <= 1'b0;
    else
      loadMode_q <= constantPowerMode;
  end

  // doze request; cleared by any communication, set wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      deepDoze_q <= 1'b0;
    else if (doDoze)
      deepDoze_q <= 1'b1;
    else if (commEvent | wakeNow)
      deepDoze_q <= 1'b0;
  end

  // full sleep entry; any traffic wakes from full sleep
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      deep_doze_q <= 1'b0;
    else if (wakeNow)
      deep_doze_q <= 1'b0;
    else if (deepDoze_q && sleepEntered)
      deep_doze_q <= 1'b1;
  end

  // hibernate request set and self clear on exit; clear forces exit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hibernateReq_q <= 1'b0;
      hibernate_q    <= 1'b0;
    end else begin
      if (doHibSet)
        hibernateReq_q <= 1'b1;
      else if (doHibClr || (hibernate_q && hibernateWake))
        hibernateReq_q <= 1'b0;
      if (doHibClr || hibernateWake)
        hibernate_q <= 1'b0;
      else if (hibernateReq_q && sleepEntered)
        hibernate_q <= 1'b1;
    end
  end

  // shutdown enable; clear leaves pin released
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shutdownEn_q <= 1'b0;
      pinLow_q     <= 1'b0;
    end else begin
      if (doSdSet)
        shutdownEn_q <= 1'b1;
      else if (doSdClr)
        shutdownEn_q <= 1'b0;
      // pin level frozen while disabled
      if (shutdownEn_q)
        pinLow_q <= shutdownCond;
    end
  end

  assign sePinOen = ~shutdownEn_q;
  // pin driven low to signal shutdown
  assign sePinOut = ~pinLow_q;

  // irq enable with retry budget; off stops pulses at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wireIrqEnable_q <= 1'b0;
      irqTries_q      <= 8'h00;
      wireIrqPulse    <= 1'b0;
    end else begin
      wireIrqPulse <= 1'b0;
      if (doIrqOn) begin
        wireIrqEnable_q <= 1'b1;
        irqTries_q      <= irqRetryCount;
      end else if (doIrqOff) begin
        wireIrqEnable_q <= 1'b0;
      end else if (tick && wireIrqEnable_q && irqCondition && irqTries_q != 8'h00) begin
        wireIrqPulse <= 1'b1;
        irqTries_q   <= irqTries_q - 8'h01;
      end
    end
  end

  // one-cycle action strobes toward the algorithm side, plus the link's dropped-message strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trackingStart <= 1'b0;
      sumStart      <= 1'b0;
      calStart      <= 1'b0;
      fullResetReq  <= 1'b0;
      msgDropped    <= 1'b0;
    end else begin
      trackingStart <= doTrack;
      sumStart      <= doSum;
      // calibration and full reset only when open
      calStart      <= doCmd & isCal;
      fullResetReq  <= doCmd & isReset;
      msgDropped    <= dropNow;
    end
  end

  // signed rate setpoint, zero after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst)
      rate_q <= 16'h0000;
    else if (wrRate)
      rate_q <= regWrData;
  end

  // read path; unmapped codes read zero
  wire gcd_word_t ctlRead = (retSel_q == GCD_RET_STATUS) ? statusWord : retWord_q;
  wire gcd_word_t rdMux   = (regAddr == `GCD_OFF_CTL)   ? ctlRead :
                            (regAddr == `GCD_OFF_RATE)  ? rate_q :
                            (regAddr == `GCD_OFF_RTIME) ? rateTime :
                            (regAddr == `GCD_OFF_TEMP)  ? temperature :
                            (regAddr == `GCD_OFF_VOLT)  ? packVoltage : 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= rdAcc;
      if (rdAcc)
        regRdData <= rdMux;
    end
  end

  assign fullSleepMode = deep_doze_q;
  assign hibernateMode = hibernate_q;
  assign clockStretch  = stretchBusy | (deep_doze_q & ~wireMode & req);

  gcd_tick_timer #(
    .CYCLES  (TICK_CYCLES),
    .ONESHOT (1'b0)
  ) u_second (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (1'b0),
    .busy    (),
    .done    (tick)
  );

  gcd_tick_timer #(
    .CYCLES  (STRETCH_CYCLES),
    .ONESHOT (1'b1)
  ) u_stretch (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .start   (wakeNow & ~wireMode),
    .busy    (stretchBusy),
    .done    ()
  );

  gcd_word_sampler u_sampler (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .tick         (tick),
    .rateSetpoint (rate_q),
    .predTimeIn   (predTimeIn),
    .tempIn       (tempIn),
    .voltIn       (voltIn),
    .rateTime     (rateTime),
    .temperature  (temperature),
    .packVoltage  (packVoltage)
  );
endmodule

// *** common/gcd_defs.svh ***
// decoder constants: offsets, codes, timing
// assumes inclusion by bare name; holds only defines
// Summary of operation
// - host writes a two-byte subcommand to the control word; it is decoded
// - version subcommands return an identification word, also sealed
// - restricted subcommands refused while sealed
// - checksum subcommand stores flash sum, sets sum-valid; sealed reads stored sum
// - reset-data subcommand returns the reset information word
// - previous-command query returns last subcommand written, only codes below seal code
// - doze request sets deep-doze bit; full sleep follows once sleep is detected
// - full-sleep traffic wakes; two-wire stretches, single-wire drops
// - hibernate-set raises request bit; bit clears itself on leaving hibernate
// - hibernate-clear drops request bit and forces hibernate exit
// - shutdown-set lets the power-off pin follow the shutdown condition
// - shutdown-clear freezes the power-off pin in high impedance
// - wire irq on: check conditions, pulse each second until off or retries spent
// - wire irq off clears enable and stops all interrupt pulses
// - seal subcommand moves open state to sealed state
// - tracking start sets update status one, voltage ok and sticky capacity update
// - status subcommand returns the 16-bit status word
// - pin-active, irq enable, shutdown, hibernate read zero after reset; load mode follows the algorithm
// - deep-doze bit clears on any communication so reads after a status write never see it set
// - rate setpoint is signed rw milliamps, resets zero, forcing time word to maximum
// - rate time read-only, clamped below maximum, refreshed each second
// - temperature and voltage words read-only; voltage limited to 6000 mV
// - data words sampled once per second; reads between return previous values
`ifndef GCD_DEFS_SVH
`define GCD_DEFS_SVH
`define GCD_OFF_CTL      8'h00
`define GCD_OFF_RATE     8'h02
`define GCD_OFF_RTIME    8'h04
`define GCD_OFF_TEMP     8'h06
`define GCD_OFF_VOLT     8'h08
`define GCD_SC_STATUS    16'h0000
`define GCD_SC_DEVTYPE   16'h0001
`define GCD_SC_FWREV     16'h0002
`define GCD_SC_HWREV     16'h0003
`define GCD_SC_SUM       16'h0004
`define GCD_SC_RSTDATA   16'h0005
`define GCD_SC_RSVD      16'h0006
`define GCD_SC_PREV      16'h0007
`define GCD_SC_PROFILE   16'h0008
`define GCD_SC_FLASHREV  16'h000C
`define GCD_SC_DOZE      16'h0010
`define GCD_SC_HIB_SET   16'h0011
`define GCD_SC_HIB_CLR   16'h0012
`define GCD_SC_SD_SET    16'h0013
`define GCD_SC_SD_CLR    16'h0014
`define GCD_SC_IRQ_ON    16'h0015
`define GCD_SC_IRQ_OFF   16'h0016
`define GCD_SC_SEAL      16'h0020
`define GCD_SC_TRACK     16'h0021
`define GCD_SC_CAL       16'h0040
`define GCD_SC_RESET     16'h0041
`define GCD_UPD_STATUS   8'h01
`define GCD_TIME_MAX     16'hFFFF
`define GCD_TIME_CLAMP   16'hFFFE
`define GCD_VOLT_MAX     16'h1770
`define GCD_RESET_WORD   16'h0000
`define GCD_CLK_HZ       40000000
`define GCD_TICK_S       1
`define GCD_STRETCH_MS   6
`endif

// *** common/gcd_pkg.sv ***
// types shared by the gauge control command decoder
// assumes nothing of its surroundings
package gcd_pkg;
  typedef logic [15:0] gcd_word_t;
  typedef enum logic {GCD_RET_STATUS, GCD_RET_WORD} gcd_ret_t;
endpackage

// *** hw/gcd_tick_timer.sv ***
// cycle counter: free-running tick or restartable one-shot busy window
// assumes start is a one-cycle pulse from the clock domain of sys_clk
`timescale 1ns/1ps
module gcd_tick_timer #(
  parameter int unsigned CYCLES  = 16,
  parameter bit          ONESHOT = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // control
  input  wire logic start,
  // status
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt_q;
  logic        run_q;
  wire  logic  atEnd = (cnt_q == 32'(CYCLES - 1));

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_q <= 32'h00000000;
      run_q <= ~ONESHOT;
      done  <= 1'b0;
    end else begin
      done <= run_q & atEnd;
      if (start) begin
        cnt_q <= 32'h00000000;
        run_q <= 1'b1;
      end else if (run_q) begin
        cnt_q <= atEnd ? 32'h00000000 : cnt_q + 32'h00000001;
        if (atEnd && ONESHOT)
          run_q <= 1'b0;
      end
    end
  end

  assign busy = run_q;
endmodule

// *** hw/gcd_word_sampler.sv ***
// once-per-second sampling of rate time, temperature and voltage words
// assumes the measurement side presents current values at all times
`timescale 1ns/1ps
`include "gcd_defs.svh"
module gcd_word_sampler
  import gcd_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // refresh pulse
  input  wire logic        tick,
  // live values
  input  wire gcd_pkg::gcd_word_t rateSetpoint,
  input  wire gcd_pkg::gcd_word_t predTimeIn,
  input  wire gcd_pkg::gcd_word_t tempIn,
  input  wire gcd_pkg::gcd_word_t voltIn,
  // sampled words
  output gcd_pkg::gcd_word_t      rateTime,
  output gcd_pkg::gcd_word_t      temperature,
  output gcd_pkg::gcd_word_t      packVoltage
);
  wire gcd_word_t timeClamped = (predTimeIn > `GCD_TIME_CLAMP) ? `GCD_TIME_CLAMP : predTimeIn;
  wire gcd_word_t timeNext = (rateSetpoint == 16'h0000) ? `GCD_TIME_MAX : timeClamped;
  wire gcd_word_t voltNext = (voltIn > `GCD_VOLT_MAX) ? `GCD_VOLT_MAX : voltIn;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rateTime    <= `GCD_TIME_MAX;
      temperature <= 16'h0000;
      packVoltage <= 16'h0000;
    end else if (tick) begin
      rateTime    <= timeNext;
      temperature <= tempIn;
      packVoltage <= voltNext;
    end
  end
endmodule

// *** sim/gcd_control_decoder_sva.sv ***
// checker for the control decoder ports
// assumes binding onto gcd_control_decoder with a single sys_clk domain
`timescale 1ns/1ps
module gcd_control_decoder_sva
  import gcd_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // watched ports
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic       regReady,
  input wire logic       regRdValid,
  input wire logic       wireMode,
  input wire logic       clockStretch,
  input wire logic       fullSleepMode,
  input wire logic       shutdownCond,
  input wire logic       sePinOut,
  input wire logic       sePinOen,
  input wire logic       irqCondition,
  input wire logic       wireIrqPulse,
  input wire logic       trackingStart,
  input wire logic [7:0] updateStatus
);
  import gcd_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RD_ANSWER: assert property ((regRdEn && !regWrEn && regReady && !fullSleepMode) |=> regRdValid)
    else $error("read taken without answer");
  AST_RD_CAUSE: assert property (regRdValid |-> $past(regRdEn && !regWrEn && regReady))
    else $error("read answer without request");
  AST_WR_WINS: assert property ((regWrEn && regRdEn && regReady) |=> !regRdValid)
    else $error("read answer for write");
  AST_STRETCH_HOLD: assert property (clockStretch |-> (!regReady && !wireMode))
    else $error("stretch while ready or single wire");
  AST_TRACK_STATUS: assert property (trackingStart |-> ##[0:1] (updateStatus == 8'h01))
    else $error("update status not one after tracking");
  AST_RESET_STATE: assert property ($fell(sys_rst) |-> (updateStatus == 8'h00 && sePinOen && !trackingStart))
    else $error("bad state after reset");
  AST_SE_FOLLOW: assert property ((!sePinOen && shutdownCond) [*3] |-> !sePinOut)
    else $error("power off pin ignores condition");
  AST_IRQ_CAUSE: assert property (wireIrqPulse |-> $past(irqCondition))
    else $error("irq pulse without condition");
  COV_TRACK: cover property (trackingStart);
  COV_STRETCH: cover property (clockStretch ##1 regReady);
  COV_IRQ: cover property (wireIrqPulse);
endmodule

bind gcd_control_decoder gcd_control_decoder_sva i_sva (.*);

// *** sim/gcd_host_model.sv ***
// host processor model driving whole words on the register port
// assumes requests launch at the falling edge and hold until regReady is sampled high
`timescale 1ns/1ps
module gcd_host_model (
  // clock
  input wire logic               sys_clk,
  // answer side
  input wire logic               regReady,
  input wire gcd_pkg::gcd_word_t regRdData,
  input wire logic               regRdValid,
  // request side
  output logic [7:0]             regAddr,
  output logic                   regWrEn,
  output logic                   regRdEn,
  output gcd_pkg::gcd_word_t     regWrData
);
  import gcd_pkg::*;
  initial begin
    regAddr = 8'hFF;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 16'hFFFF;
  end
  task automatic xfer(input bit wr, input logic [7:0] a, input gcd_word_t d, output gcd_word_t q);
    int n;
    @(negedge sys_clk);
    regAddr = a;
    regWrEn = wr;
    regRdEn = !wr;
    regWrData = d;
    n = 0;
    @(posedge sys_clk);
    while (regReady !== 1'b1 && n < 400) begin
      n++;
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    q = regRdData;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    // released lines show the inverse so stale values cannot pass
    regAddr = ~a;
    regWrData = ~d;
  endtask
endmodule

// *** sim/test_gauge_control_command_decoder.sv ***
// self-checking bench for the control decoder
// assumes shortened tick and stretch counts
`timescale 1ns/1ps
`include "gcd_defs.svh"
module test_gauge_control_command_decoder;
  import gcd_pkg::*;
  localparam int TICK = 50;
  localparam int STR  = 10;
  logic sys_clk, sys_rst, regWrEn, regRdEn, regReady, regRdValid, wireMode, clockStretch, msgDropped;
  logic sleepEntered, hibernateWake, fullSleepMode, hibernateMode, shutdownCond, sePinOut, sePinOen;
  logic irqCondition, wireIrqPulse, voltageUnsuitable, coulombCalActive, boardCalActive, constantPowerMode;
  logic raUpdatesOff, trackingStart, sumStart, calStart, fullResetReq;
  logic [7:0] regAddr, irqRetryCount, updateStatus;
  gcd_word_t  regWrData, regRdData, flashSum, resetInfo, predTimeIn, tempIn, voltIn, q, sum, rate;
  bit         sealed, sum_valid, irqEn, sdEn, hib, voltage_ok, capacity_update_on;
  int         error_cnt, checked, nIrq, nStr, nSum, nCal, nRst, n0, n1;
  gcd_word_t  codes[5] = '{`GCD_SC_FWREV, `GCD_SC_HWREV, `GCD_SC_FLASHREV, `GCD_SC_DEVTYPE, `GCD_SC_PROFILE};
  gcd_word_t  ids[5]   = '{16'h0100, 16'h00A0, 16'h0001, 16'h0A5A, 16'h0001};

  gcd_control_decoder #(.TICK_CYCLES(TICK), .STRETCH_CYCLES(STR)) i_dut (.*);
  gcd_host_model i_host (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    nIrq += wireIrqPulse;
    nStr += clockStretch;
    nSum += sumStart;
    nCal += calStart;
    nRst += fullResetReq;
  end

  task automatic check(input string what, input gcd_word_t exp, input gcd_word_t seen);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input gcd_word_t d);
    gcd_word_t t;
    i_host.xfer(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a, output gcd_word_t v);
    i_host.xfer(1'b0, a, 16'h0000, v);
  endtask
  // pin-active bit masked: it hangs on latched pin timing
  task automatic chk_stat();
    gcd_word_t e;
    {coulombCalActive, boardCalActive, constantPowerMode, raUpdatesOff} = 4'($urandom);
    wr(`GCD_OFF_CTL, `GCD_SC_STATUS);
    rd(`GCD_OFF_CTL, q);
    e = {1'b0, sealed, sealed, sum_valid, coulombCalActive, boardCalActive, 1'b0, irqEn,
         sdEn, hib, 1'b0, sleepEntered, constantPowerMode, raUpdatesOff, voltage_ok, capacity_update_on};
    check("status word", e & 16'h7FFF, q & 16'h7FFF);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(25 * 40000);
    error_cnt++;
    conclude();
  end

  initial begin
    void'($urandom(32'h5326));
    {sys_rst, wireMode, sleepEntered, hibernateWake, shutdownCond, irqCondition, voltageUnsuitable} = 7'h40;
    {coulombCalActive, boardCalActive, constantPowerMode, raUpdatesOff} = 4'h0;
    irqRetryCount = 8'h02;
    {flashSum, resetInfo, predTimeIn, tempIn, voltIn} = {$urandom, $urandom, 16'($urandom)};
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(`GCD_OFF_CTL, q);
    check("reset status", 16'h0000, q);
    rd(`GCD_OFF_RATE, q);
    check("reset rate", 16'h0000, q);
    rd(`GCD_OFF_RTIME, q);
    check("zero rate time", `GCD_TIME_MAX, q);
    rd(8'h0A, q);
    check("unmapped", 16'h0000, q);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      wr(`GCD_OFF_CTL, codes[i]);
      rd(`GCD_OFF_CTL, q);
      check("id word", ids[i], q);
    end
    $display("test ids done");
    wr(`GCD_OFF_CTL, `GCD_SC_HIB_SET);
    wr(`GCD_OFF_CTL, `GCD_SC_SD_SET);
    wr(`GCD_OFF_CTL, `GCD_SC_IRQ_ON);
    {hib, sdEn, irqEn} = 3'b111;
    chk_stat();
    shutdownCond = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("pin level", 16'h0000, 16'(sePinOut));
    wr(`GCD_OFF_CTL, `GCD_SC_SD_CLR);
    sdEn = 1'b0;
    check("pin released", 16'h0001, 16'(sePinOen));
    shutdownCond = 1'b0;
    wr(`GCD_OFF_CTL, `GCD_SC_HIB_CLR);
    wr(`GCD_OFF_CTL, `GCD_SC_IRQ_OFF);
    {hib, irqEn} = 2'b00;
    chk_stat();
    irqCondition = 1'b1;
    wr(`GCD_OFF_CTL, `GCD_SC_IRQ_ON);
    n0 = nIrq;
    repeat (TICK * 4) @(negedge sys_clk);
    check("irq tries", 16'h0002, 16'(nIrq - n0));
    irqRetryCount = 8'h05;
    wr(`GCD_OFF_CTL, `GCD_SC_IRQ_OFF);
    n0 = nIrq;
    repeat (TICK * 2) @(negedge sys_clk);
    check("irq stopped", 16'h0000, 16'(nIrq - n0));
    irqCondition = 1'b0;
    $display("test bits done");
    n0 = nSum;
    sum = flashSum;
    wr(`GCD_OFF_CTL, `GCD_SC_SUM);
    rd(`GCD_OFF_CTL, q);
    sum_valid = 1'b1;
    check("flash sum", sum, q);
    check("sum start", 16'h0001, 16'(nSum - n0));
    wr(`GCD_OFF_CTL, `GCD_SC_RSTDATA);
    rd(`GCD_OFF_CTL, q);
    check("reset info", resetInfo, q);
    wr(`GCD_OFF_CTL, `GCD_SC_SD_CLR);
    wr(`GCD_OFF_CTL, `GCD_SC_PREV);
    rd(`GCD_OFF_CTL, q);
    check("previous", `GCD_SC_SD_CLR, q);
    wr(`GCD_OFF_CTL, `GCD_SC_TRACK);
    {voltage_ok, capacity_update_on} = 2'b11;
    check("update status", 16'h0001, {8'h00, updateStatus});
    chk_stat();
    voltageUnsuitable = 1'b1;
    voltage_ok = 1'b0;
    repeat (2) @(negedge sys_clk);
    voltageUnsuitable = 1'b0;
    chk_stat();
    $display("test commands done");
    rate = 16'($urandom) | 16'h8000;
    wr(`GCD_OFF_RATE, rate);
    predTimeIn = 16'hFFFF;
    repeat (TICK + 4) @(negedge sys_clk);
    rd(`GCD_OFF_RATE, q);
    check("rate", rate, q);
    rd(`GCD_OFF_RTIME, q);
    check("rate time clamp", `GCD_TIME_CLAMP, q);
    rd(`GCD_OFF_TEMP, q);
    check("temperature", tempIn, q);
    rd(`GCD_OFF_VOLT, q);
    check("voltage", (voltIn > `GCD_VOLT_MAX) ? `GCD_VOLT_MAX : voltIn, q);
    $display("test words done");
    wr(`GCD_OFF_CTL, `GCD_SC_DOZE);
    sleepEntered = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("full sleep", 16'h0001, 16'(fullSleepMode));
    n0 = nStr;
    chk_stat();
    check("stretch long", 16'h0001, 16'(nStr - n0 >= STR));
    check("woken", 16'h0000, 16'(fullSleepMode));
    sleepEntered = 1'b0;
    $display("test doze done");
    wr(`GCD_OFF_CTL, `GCD_SC_SEAL);
    sealed = 1'b1;
    chk_stat();
    flashSum = ~sum;
    wr(`GCD_OFF_CTL, `GCD_SC_SUM);
    rd(`GCD_OFF_CTL, q);
    check("sealed sum", sum, q);
    {n0, n1} = {nCal, nRst};
    wr(`GCD_OFF_CTL, `GCD_SC_CAL);
    wr(`GCD_OFF_CTL, `GCD_SC_RESET);
    wr(`GCD_OFF_CTL, `GCD_SC_TRACK);
    check("sealed refusals", 16'h0000, 16'(nCal - n0 + nRst - n1));
    chk_stat();
    wr(`GCD_OFF_CTL, `GCD_SC_FWREV);
    rd(`GCD_OFF_CTL, q);
    check("sealed id", ids[0], q);
    $display("test seal done");
    conclude();
  end
endmodule
